/* src/status_pages_pkg.sv */
// Shared constants and types for the status readout page block
package status_pages_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and answers
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_PAGE_SELECT     = 6'h29;
  localparam logic [5:0] IDX_INTERNAL_STATUS = 6'h2a;
  localparam logic [5:0] IDX_STRENGTH        = 6'h2b;
  localparam logic [5:0] IDX_CAL_VIEW        = 6'h2c;
  localparam logic [5:0] IDX_ADC_VIEW        = 6'h2d;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET       = 8'h00;
  localparam logic [7:0] COUNT_MAX         = 8'hff;
  localparam logic [1:0] CAL_PAGE_GAIN     = 2'h0;

  // ----------------------------------------------------------------
  // Signal-strength page codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SP_LIVE     = 4'h0;
  localparam logic [3:0] SP_QUIET    = 4'h2;
  localparam logic [3:0] SP_PILOT    = 4'h4;
  localparam logic [3:0] SP_DATA     = 4'h6;
  localparam logic [3:0] SP_PEAK     = 4'h8;
  localparam logic [3:0] SP_CD_TIME  = 4'hc;
  localparam logic [3:0] SP_CD_LEN   = 4'hd;
  localparam logic [3:0] SP_ERR_TIME = 4'he;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] adc_view_page;
    logic [1:0] cal_view_page;
    logic [3:0] strength_view_page;
  } page_select_t;

  typedef struct packed {
    logic       subc_in_phase;
    logic [2:0] agc_step;
    logic       decode_on_q;
    logic       carrier_level_stable;
    logic       pll_locked;
    logic       osc_stable;
  } internal_status_t;

  typedef struct packed {
    logic [3:0] q;
    logic [3:0] i;
  } iq_t;

  typedef struct packed {
    logic [2:0] q;
    logic [2:0] i;
  } gain_limit_t;

  typedef struct packed {
    logic rx_start;
    logic tx_start;
    logic rx_active;
    logic store_strength;
    logic pilot_seen;
    logic second_byte;
    logic rx_bit;
    logic protocol_error;
    logic collision_detect;
  } rx_events_t;

  typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_t;

  // Word index from a byte address
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[7:2];
  endfunction

endpackage

/* src/level_sync3.sv */
// Three-stage synchroniser with agreement filter for level inputs
module level_sync3 #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_sync_out;

  // Accept a new level only once stages two and three agree
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_comb begin
        next_sync_out[b] = (s2[b] == s3[b]) ? s3[b] : sync_out[b];
      end
    end
  endgenerate

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      sync_out <= '0;
    end else begin
      s1       <= async_in;
      s2       <= s1;
      s3       <= s2;
      sync_out <= next_sync_out;
    end
  end

endmodule

/* src/strength_capture.sv */
// Captured signal-strength snapshots and reception timing
module strength_capture
  import status_pages_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Receiver side
  input  wire iq_t        live,
  input  wire rx_events_t ev,
  // Captured views
  output iq_t             quiet,
  output iq_t             pilot,
  output iq_t             data,
  output iq_t             peak,
  output logic [7:0]      cd_time,
  output logic [7:0]      cd_len,
  output logic [7:0]      err_time
);

  logic [7:0] cycles;
  logic [7:0] bits;
  logic       cd_seen;
  logic       cd_ended;
  logic       err_seen;
  iq_t        next_quiet, next_pilot, next_data, next_peak;
  logic [7:0] next_cd_time, next_cd_len, next_err_time, next_cycles, next_bits;
  logic       next_cd_seen, next_cd_ended, next_err_seen;

  // Snapshots and timers; counters saturate rather than wrap
  always_comb begin
    next_quiet    = quiet;
    next_pilot    = pilot;
    next_data     = data;
    next_peak     = peak;
    next_cd_time  = cd_time;
    next_cd_len   = cd_len;
    next_err_time = err_time;
    next_cycles   = cycles;
    next_bits     = bits;
    next_cd_seen  = cd_seen;
    next_cd_ended = cd_ended;
    next_err_seen = err_seen;
    if (ev.store_strength) next_quiet = live;   // [RQ4]
    if (ev.pilot_seen) next_pilot = live;       // [RQ5]
    if (ev.second_byte) next_data = live;       // [RQ5]
    if (ev.rx_start) begin
      next_peak     = '0;
      next_cycles   = COUNT_RESET;
      next_bits     = COUNT_RESET;
      next_cd_len   = COUNT_RESET;
      next_cd_seen  = 1'b0;
      next_cd_ended = 1'b0;
      next_err_seen = 1'b0;
    end else begin
      if (ev.rx_active) begin
        if (live.q > peak.q) next_peak.q = live.q;  // [RQ5]
        if (live.i > peak.i) next_peak.i = live.i;  // [RQ5]
        if (cycles != COUNT_MAX) next_cycles = cycles + 8'h01;
      end
      if (ev.rx_bit && bits != COUNT_MAX) next_bits = bits + 8'h01;
      if (ev.collision_detect && !cd_seen) begin
        next_cd_time = cycles;                      // [RQ6]
        next_cd_seen = 1'b1;
      end
      if (ev.collision_detect && !cd_ended && cd_len != COUNT_MAX) begin
        next_cd_len = cd_len + 8'h01;               // [RQ6]
      end
      if (!ev.collision_detect && cd_seen) next_cd_ended = 1'b1;
      if (ev.protocol_error && !err_seen) begin
        next_err_time = bits;                       // [RQ7]
        next_err_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quiet    <= '0;
      pilot    <= '0;
      data     <= '0;
      peak     <= '0;
      cd_time  <= COUNT_RESET;
      cd_len   <= COUNT_RESET;
      err_time <= COUNT_RESET;
      cycles   <= COUNT_RESET;
      bits     <= COUNT_RESET;
      cd_seen  <= 1'b0;
      cd_ended <= 1'b0;
      err_seen <= 1'b0;
    end else begin
      quiet    <= next_quiet;
      pilot    <= next_pilot;
      data     <= next_data;
      peak     <= next_peak;
      cd_time  <= next_cd_time;
      cd_len   <= next_cd_len;
      err_time <= next_err_time;
      cycles   <= next_cycles;
      bits     <= next_bits;
      cd_seen  <= next_cd_seen;
      cd_ended <= next_cd_ended;
      err_seen <= next_err_seen;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_quiet_capture; // [RQ4]
    @(posedge aclk) disable iff (!aresetn)
      ev.store_strength |=> quiet == $past(live);
  endproperty
  a_quiet_capture: assert property (p_quiet_capture) else $error("quiet level not captured");

  property p_pilot_capture; // [RQ5]
    @(posedge aclk) disable iff (!aresetn)
      ev.pilot_seen |=> pilot == $past(live);
  endproperty
  a_pilot_capture: assert property (p_pilot_capture) else $error("pilot level not captured");

  property p_cd_first; // [RQ6]
    @(posedge aclk) disable iff (!aresetn)
      (ev.collision_detect && !cd_seen && !ev.rx_start) |=>
        cd_seen && cd_time == $past(cycles);
  endproperty
  a_cd_first: assert property (p_cd_first) else $error("collision time wrong");

  property p_err_first; // [RQ7]
    @(posedge aclk) disable iff (!aresetn)
      (ev.protocol_error && !err_seen && !ev.rx_start) |=>
        err_time == $past(bits) ##1 err_time == $past(err_time);
  endproperty
  a_err_first: assert property (p_err_first) else $error("error bit time wrong");

endmodule

/* src/status_readout_pages.sv */
// AXI4-Lite status readout page registers of the reader front end
//
// How it works
// (RQ1) Page-select bits 7:6 choose 2Dh view
// (RQ2) Page-select bits 5:4 choose 2Ch view
// (RQ3) Strength page 0000 shows live I/Q
// (RQ4) Page 0010 shows quiet level from store
// (RQ5) Pages 0100/0110/1000: pilot, second byte, peak
// (RQ6) Pages 1100/1101: collision start time, duration
// (RQ7) Page 1110: first protocol error, in bits
// (RQ8) Software writes only defined strength page codes
// (RQ9) Status bit 7 reports sub-carrier phase
// (RQ10) Status bits 6:4 report gain step
// (RQ11) Bit 3 decode channel, held until transmit
// (RQ12) Bit 2 set while carrier level stable
// (RQ13) Bit 1 set while synthesizer locked
// (RQ14) Bit 0 set once oscillator stable
// (RQ15) Strength register bits 7:4 hold Q
// (RQ16) Strength register bits 3:0 hold I
// (RQ17) 2Ch page 00 shows gain limit Q, I
// (RQ18) Reads never change any state
//
// Our own choice: the AXI4-Lite register port.
module status_readout_pages
  import status_pages_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Analog status levels, asynchronous
  input  wire internal_status_t  status_raw,
  // Receiver logic, same clock
  input  wire iq_t               live_strength,
  input  wire gain_limit_t       gain_limit,
  input  wire rx_events_t        rx_ev,
  // Other paged views
  input  wire logic [3:1][7:0]   cal_page_data,
  input  wire logic [3:0][7:0]   adc_page_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  page_select_t     page_select;
  page_select_t     next_page_select;
  internal_status_t status_sync;
  internal_status_t status_shown;
  logic             decode_on_q;
  logic             next_decode_on_q;
  wr_state_t        wr_state;
  wr_state_t        next_wr_state;
  rd_state_t        rd_state;
  rd_state_t        next_rd_state;
  logic             aw_held;
  logic             w_held;
  logic             next_aw_held;
  logic             next_w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] next_aw_addr_q;
  logic [7:0]       w_byte_q;
  logic [7:0]       next_w_byte_q;
  logic             w_lane_q;
  logic             next_w_lane_q;
  logic [1:0]       next_bresp;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]       next_rresp;
  iq_t              quiet, pilot, data_lvl, peak;
  logic [7:0]       cd_time, cd_len, err_time;
  logic [7:0]       read_byte;
  logic             read_ok;

  // ----------------------------------------------------------------
  // Status synchronisation and capture helpers
  // ----------------------------------------------------------------
  level_sync3 #(
    .WIDTH ($bits(internal_status_t))
  ) u_status_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (status_raw),
    .sync_out (status_sync)
  );

  strength_capture u_capture (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .live     (live_strength),
    .ev       (rx_ev),
    .quiet    (quiet),
    .pilot    (pilot),
    .data     (data_lvl),
    .peak     (peak),
    .cd_time  (cd_time),
    .cd_len   (cd_len),
    .err_time (err_time)
  );

  // Decode channel follows the receiver during reception only
  always_comb begin
    next_decode_on_q = decode_on_q;
    if (rx_ev.tx_start) begin
      next_decode_on_q = 1'b0;                          // [RQ11]
    end else if (rx_ev.rx_active) begin
      next_decode_on_q = status_sync.decode_on_q;       // [RQ11]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decode_on_q <= 1'b0;
    end else begin
      decode_on_q <= next_decode_on_q;
    end
  end

  // Shown status; each field straight from its synchronised level, except decode_on_q, which comes from the held register
  always_comb begin
    status_shown             = status_sync;             // [RQ9] [RQ10] [RQ12] [RQ13] [RQ14]
    status_shown.decode_on_q = decode_on_q;             // [RQ11]
  end

  // ----------------------------------------------------------------
  // Read data selection, purely combinational so reads leave state alone
  // ----------------------------------------------------------------
  always_comb begin
    read_byte = 8'h00;
    read_ok   = 1'b1;
    case (reg_index(araddr))
      IDX_PAGE_SELECT:     read_byte = page_select;
      IDX_INTERNAL_STATUS: read_byte = status_shown;
      IDX_STRENGTH: begin
        // Unused page codes read as zero; software must avoid them [RQ8]
        case (page_select.strength_view_page)
          SP_LIVE:     read_byte = live_strength;       // [RQ3] [RQ15] [RQ16]
          SP_QUIET:    read_byte = quiet;               // [RQ4]
          SP_PILOT:    read_byte = pilot;               // [RQ5]
          SP_DATA:     read_byte = data_lvl;            // [RQ5]
          SP_PEAK:     read_byte = peak;                // [RQ5]
          SP_CD_TIME:  read_byte = cd_time;             // [RQ6]
          SP_CD_LEN:   read_byte = cd_len;              // [RQ6]
          SP_ERR_TIME: read_byte = err_time;            // [RQ7]
          default:     read_byte = 8'h00;
        endcase
      end
      IDX_CAL_VIEW: begin
        if (page_select.cal_view_page == CAL_PAGE_GAIN) begin
          read_byte = {2'b00, gain_limit};              // [RQ17]
        end else begin
          read_byte = cal_page_data[page_select.cal_view_page]; // [RQ2]
        end
      end
      IDX_ADC_VIEW: read_byte = adc_page_data[page_select.adc_view_page]; // [RQ1]
      default:      read_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel: one outstanding read
  // ----------------------------------------------------------------
  assign arready = (rd_state == RD_IDLE);
  assign rvalid  = (rd_state == RD_DATA);

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      RD_IDLE: begin
        if (arvalid) begin
          next_rdata    = {24'h000000, read_byte};      // [RQ18]
          next_rresp    = read_ok ? RESP_OKAY : RESP_SLVERR;
          next_rd_state = RD_DATA;
        end
      end
      RD_DATA: begin
        if (rready) next_rd_state = RD_IDLE;
      end
      default: next_rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      rdata    <= '0;
      rresp    <= RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel: address and data accepted in any order
  // ----------------------------------------------------------------
  assign awready = (wr_state == WR_COLLECT) && !aw_held;
  assign wready  = (wr_state == WR_COLLECT) && !w_held;
  assign bvalid  = (wr_state == WR_RESP);

  // Page select is the only writable register
  always_comb begin
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wbyte;
    logic              lane;
    logic              have_aw;
    logic              have_w;
    addr             = aw_held ? aw_addr_q : awaddr;
    wbyte            = w_held ? w_byte_q : wdata[7:0];
    lane             = w_held ? w_lane_q : wstrb[0];
    have_aw          = aw_held || (awvalid && awready);
    have_w           = w_held || (wvalid && wready);
    next_wr_state    = wr_state;
    next_aw_held     = aw_held;
    next_w_held      = w_held;
    next_aw_addr_q   = aw_addr_q;
    next_w_byte_q    = w_byte_q;
    next_w_lane_q    = w_lane_q;
    next_bresp       = bresp;
    next_page_select = page_select;
    case (wr_state)
      WR_COLLECT: begin
        if (awvalid && awready) begin
          next_aw_held   = 1'b1;
          next_aw_addr_q = awaddr;
        end
        if (wvalid && wready) begin
          next_w_held   = 1'b1;
          next_w_byte_q = wdata[7:0];
          next_w_lane_q = wstrb[0];
        end
        if (have_aw && have_w) begin
          if (reg_index(addr) == IDX_PAGE_SELECT) begin
            if (lane) next_page_select = wbyte;         // [RQ1] [RQ2]
            next_bresp = RESP_OKAY;
          end else begin
            next_bresp = RESP_SLVERR;                   // [RQ18]
          end
          next_wr_state = WR_RESP;
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
        end
      end
      WR_RESP: begin
        if (bready) next_wr_state = WR_COLLECT;
      end
      default: next_wr_state = WR_COLLECT;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state    <= WR_COLLECT;
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr_q   <= '0;
      w_byte_q    <= 8'h00;
      w_lane_q    <= 1'b0;
      bresp       <= RESP_OKAY;
      page_select <= PAGE_SELECT_RESET;
    end else begin
      wr_state    <= next_wr_state;
      aw_held     <= next_aw_held;
      w_held      <= next_w_held;
      aw_addr_q   <= next_aw_addr_q;
      w_byte_q    <= next_w_byte_q;
      w_lane_q    <= next_w_lane_q;
      bresp       <= next_bresp;
      page_select <= next_page_select;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_adc_view; // [RQ1]
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_index(araddr) == IDX_ADC_VIEW) |=>
        rvalid && rdata[7:0] == $past(adc_page_data[page_select.adc_view_page]);
  endproperty
  a_adc_view: assert property (p_adc_view) else $error("adc view data wrong");

  property p_cal_view; // [RQ2]
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_index(araddr) == IDX_CAL_VIEW &&
       page_select.cal_view_page != CAL_PAGE_GAIN) |=>
        rdata[7:0] == $past(cal_page_data[page_select.cal_view_page]);
  endproperty
  a_cal_view: assert property (p_cal_view) else $error("cal view data wrong");

  property p_gain_limit; // [RQ17]
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_index(araddr) == IDX_CAL_VIEW &&
       page_select.cal_view_page == CAL_PAGE_GAIN) |=>
        rdata[7:6] == 2'b00 && rdata[5:0] == $past(gain_limit);
  endproperty
  a_gain_limit: assert property (p_gain_limit) else $error("gain limit view wrong");

  property p_live_strength; // [RQ3]
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_index(araddr) == IDX_STRENGTH &&
       page_select.strength_view_page == SP_LIVE) |=>
        rdata[7:4] == $past(live_strength.q) && rdata[3:0] == $past(live_strength.i);
  endproperty
  a_live_strength: assert property (p_live_strength) else $error("live strength wrong");

  property p_status_read; // [RQ9]
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_index(araddr) == IDX_INTERNAL_STATUS) |=>
        rdata == {24'h000000, $past(status_shown)} && rresp == RESP_OKAY;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_decode_clear; // [RQ11]
    @(posedge aclk) disable iff (!aresetn)
      rx_ev.tx_start |=> !decode_on_q;
  endproperty
  a_decode_clear: assert property (p_decode_clear) else $error("decode channel not cleared");

  property p_read_no_effect; // [RQ18]
    @(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && !(wr_state == WR_COLLECT && next_wr_state == WR_RESP)) |=>
        page_select == $past(page_select);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) else $error("read changed page select");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
      (wr_state == WR_COLLECT && (aw_held || awvalid) && (w_held || wvalid)) |=> bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response missing");

endmodule

/* verif/tb_top.sv */
// Self-checking testbench for the status readout page registers
module tb_top
  import status_pages_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus signals and device
  // ------------------------------------------------------------
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = 4'hf;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  internal_status_t  status_raw = '0;
  iq_t               live_strength = '0;
  gain_limit_t       gain_limit = '0;
  rx_events_t        rx_ev = '0;
  logic [3:1][7:0]   cal_page_data = '0;
  logic [3:0][7:0]   adc_page_data = '0;
  int                fails = 0, n_compared = 0, cyc = 0;
  logic [31:0]       seed = 32'ha07ad75e;
  localparam logic [3:0] CAP_CODE [3] = '{SP_QUIET, SP_PILOT, SP_DATA};
  localparam int         CAP_BIT  [3] = '{5, 4, 3};

  status_readout_pages DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .status_raw, .live_strength, .gain_limit, .rx_ev,
    .cal_page_data, .adc_page_data);

  // Clock and hang guard, a few hundred cycles are expected
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rn();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] exp_cal(input int j);
    return (j == 0) ? {26'h0, gain_limit} : {24'h0, cal_page_data[j]};
  endfunction
  function automatic logic [7:0] peak(input logic [7:0] a, input logic [7:0] b);
    return {(a[7:4] > b[7:4]) ? a[7:4] : b[7:4], (a[3:0] > b[3:0]) ? a[3:0] : b[3:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t response %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs read at the rising edge still hold what the design sampled there
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic hb;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      hb = bvalid;
      r  = bresp;
    end while (!hb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hr;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      hr = rvalid;
      d  = rdata;
      r  = rresp;
    end while (!hr);
    rready <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk_resp(r, RESP_OKAY);
  endtask
  task automatic setb(input int b, input logic v);
    @(posedge aclk);
    rx_ev[b] <= v;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [31:0] v, d;
    logic [1:0]  r;
    logic [7:0]  pk;
    int          n;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    v = rn();
    cal_page_data <= v[23:0];
    gain_limit    <= v[29:24];
    adc_page_data <= rn();
    rdx(8'ha4, 32'h0);
    for (int i = 0; i < 4; i++) for (int j = 0; j < 4; j++) begin
      wr(8'ha4, {i[1:0], j[1:0], 4'h0}, r);
      chk_resp(r, RESP_OKAY);
      rdx(8'hb4, {24'h0, adc_page_data[i]});
      rdx(8'hb0, exp_cal(j));
    end
    $display("page views done");
    wr(8'ha4, 8'h00, r);
    repeat (4) begin
      v = rn();
      live_strength <= v[7:0];
      rdx(8'hac, {24'h0, v[7:0]});
    end
    // Decode channel forced to Q so the clear after transmit is visible
    setb(8, 1'b1);
    setb(8, 1'b0);
    setb(6, 1'b1);
    v = rn() | 32'h8;
    status_raw <= v[7:0];
    repeat (8) @(posedge aclk);
    rdx(8'ha8, {24'h0, v[7:0]});
    setb(6, 1'b0);
    setb(7, 1'b1);
    setb(7, 1'b0);
    repeat (8) @(posedge aclk);
    rdx(8'ha8, {24'h0, v[7:4], 1'b0, v[2:0]});
    $display("status done");
    foreach (CAP_CODE[k]) begin
      v = rn();
      live_strength <= v[7:0];
      setb(CAP_BIT[k], 1'b1);
      setb(CAP_BIT[k], 1'b0);
      live_strength <= ~v[7:0];
      wr(8'ha4, {4'h0, CAP_CODE[k]}, r);
      rdx(8'hac, {24'h0, v[7:0]});
    end
    setb(8, 1'b1);
    setb(8, 1'b0);
    setb(6, 1'b1);
    pk = 8'h00;
    repeat (5) begin
      v = rn();
      live_strength <= v[7:0];
      pk = peak(pk, v[7:0]);
      @(posedge aclk);
    end
    setb(6, 1'b0);
    wr(8'ha4, {4'h0, SP_PEAK}, r);
    rdx(8'hac, {24'h0, pk});
    $display("captures done");
    setb(8, 1'b1);
    setb(8, 1'b0);
    v = rn();
    n = int'(v[2:0]) + 2;
    repeat (n) begin
      setb(2, 1'b1);
      setb(2, 1'b0);
    end
    setb(1, 1'b1);
    setb(1, 1'b0);
    wr(8'ha4, {4'h0, SP_ERR_TIME}, r);
    rdx(8'hac, n);
    setb(8, 1'b1);
    setb(8, 1'b0);
    setb(6, 1'b1);
    setb(0, 1'b1);
    repeat (n - 1) @(posedge aclk);
    setb(0, 1'b0);
    setb(6, 1'b0);
    wr(8'ha4, {4'h0, SP_CD_TIME}, r);
    rdx(8'hac, 32'h1);
    wr(8'ha4, {4'h0, SP_CD_LEN}, r);
    rdx(8'hac, n);
    $display("timers done");
    rd(8'hfc, d, r);
    chk_resp(r, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'ha8, 8'hff, r);
    chk_resp(r, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(8'ha4, 8'hff, r);
    chk_resp(r, RESP_OKAY);
    wstrb <= 4'hf;
    rdx(8'ha4, {4'h0, SP_CD_LEN});
    $display("refusals done");
    end_sim();
  end
endmodule
